// ===== rtl/cpc_pkg.sv
// Shared constants of the capture/compare/PWM control block.
`default_nettype none
package cpc_pkg;
  // ==========================================================
  // Sizes
  localparam int unsigned NUM_UNITS = 2;
  localparam int unsigned NUM_GENS = 2;
  localparam int unsigned NUM_TMR = 3;
  localparam int unsigned PWM_W = 10;
  localparam int unsigned UNIT_STRIDE = 16;
  localparam int unsigned NUM_SRC = 5;
  // ==========================================================
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CAPSRC = 8'h04;
  localparam logic [7:0] OFS_DLO = 8'h08;
  localparam logic [7:0] OFS_DHI = 8'h0c;
  localparam logic [7:0] OFS_TMRS = 8'h20;
  localparam logic [7:0] OFS_OUTCFG = 8'h24;
  localparam logic [7:0] OFS_GEN_A = 8'h28;
  localparam logic [7:0] OFS_GEN_B = 8'h2c;
  // ==========================================================
  // Field positions
  localparam int unsigned CTRL_EN_BIT = 7;
  localparam int unsigned CTRL_OUT_BIT = 5;
  localparam int unsigned CTRL_FMT_BIT = 4;
  localparam int unsigned GEN_EN_BIT = 15;
  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] TMRS_RST = 8'h55;
  localparam logic [1:0] CAPSRC_RST = 2'h0;
  localparam logic [1:0] OUTCFG_RST = 2'h0;
  localparam logic [15:0] DATA_RST = 16'h0000;
  // ==========================================================
  // Mode codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOG_CLR = 4'h1;
  localparam logic [3:0] MODE_TOG = 4'h2;
  localparam logic [3:0] MODE_CAP_ANY = 4'h3;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4 = 4'h6;
  localparam logic [3:0] MODE_CAP_16 = 4'h7;
  localparam logic [3:0] MODE_SET = 4'h8;
  localparam logic [3:0] MODE_CLR = 4'h9;
  localparam logic [3:0] MODE_PULSE = 4'ha;
  localparam logic [3:0] MODE_PULSE_CLR = 4'hb;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;
  localparam logic [3:0] PRESC_4_LAST = 4'h3;
  localparam logic [3:0] PRESC_16_LAST = 4'hf;
  // ==========================================================
  // Capture sources and timer selection
  localparam logic [1:0] CTS_PIN = 2'h0;
  localparam logic [1:0] CTS_CMP_A = 2'h1;
  localparam logic [1:0] CTS_CMP_B = 2'h2;
  localparam logic [1:0] CTS_PIN_CHG = 2'h3;
  localparam logic [1:0] TSEL_NONE = 2'h0;
endpackage
`default_nettype wire

// ===== rtl/cpc_pwm.sv
// Pulse-width generator driven by an external narrow timer count.
`default_nettype none
module cpc_pwm #(
  parameter int unsigned WIDTH = 10
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic run,
  input wire logic [WIDTH-1:0] width,
  // Timer
  input wire logic [WIDTH-1:0] cnt,
  input wire logic period_start,
  // Output
  output logic level_ff
);
  logic [WIDTH-1:0] width_ff;

  if (WIDTH < 2) begin : g_chk
    $error("cpc_pwm needs WIDTH of at least two");
  end

  // Width is taken at a period start or while stopped, so a running duty change never glitches.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      width_ff <= '0;
    end else if (period_start || !run) begin
      width_ff <= width;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_ff <= 1'b0;
    end else begin
      level_ff <= run && (cnt < width_ff);
    end
  end
endmodule // cpc_pwm
`default_nettype wire

// ===== rtl/cpc_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs.
`default_nettype none
module cpc_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  if (WIDTH < 1) begin : g_chk
    $error("cpc_sync needs WIDTH of at least one");
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= '0;
      sync_out <= '0;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule // cpc_sync
`default_nettype wire

// ===== rtl/cpc_top.sv
// Capture/compare/PWM control: two units, two PWM generators, AHB-Lite registers.
// Contract
// - A unit runs only while its enable bit is one.
// - The control register shows the live output level, read-only.
// - In PWM the format bit picks left or right alignment; otherwise ignored.
// - Set and clear compare levels hold until mode is zeroed or disabled.
// - Capture on any edge, falling, rising, fourth or sixteenth rising edge.
// - Compare match toggles output; one code also clears the selected timer.
// - Compare match pulses output; one code also clears the selected timer.
// - Every capture, match or PWM period sets the unit flag.
// - Unit timer select picks timer pair one, two or three.
// - Timer selection also holds selects for two PWM generators.
// - Every timer select resets to the first timer pair.
// - All units may run at once and share one timer.
// - Capture source is remapped pin, comparator A, comparator B or pin change.
// - Capture loads the selected wide timer value into the data pair.
// - Compare checks the data pair against the selected wide timer.
// - Right alignment takes width from low byte and two high-byte bits.
// - Left alignment takes width from high byte and top two low bits.
// - Output modes offer open-drain drive instead of push-pull.
// - Unused capture-source and control bits read as zero.
`default_nettype none
module cpc_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Timers
  input wire logic [47:0] wide_timer_val,
  output logic [2:0] wide_timer_clear,
  input wire logic [29:0] narrow_timer_cnt,
  input wire logic [2:0] narrow_timer_period,
  // Capture sources
  input wire logic [1:0] input_remap_pin,
  input wire logic comparator_a_result,
  input wire logic comparator_b_result,
  input wire logic pin_change_signal,
  // Outputs
  output logic [1:0] unit_out,
  output logic [1:0] unit_out_oe,
  output logic [1:0] pwm_gen_out,
  output logic [1:0] unit_flag_set
);
  localparam int unsigned NU = cpc_pkg::NUM_UNITS;
  localparam int unsigned PW = cpc_pkg::PWM_W;

  // ==========================================================
  // Timer pickers
  function automatic logic [15:0] pick_wide(logic [1:0] s, logic [47:0] v);
    unique case (s)
      2'h1: pick_wide = v[15:0];
      2'h2: pick_wide = v[31:16];
      2'h3: pick_wide = v[47:32];
      default: pick_wide = 16'h0000;
    endcase
  endfunction

  function automatic logic [9:0] pick_narrow(logic [1:0] s, logic [29:0] v);
    unique case (s)
      2'h1: pick_narrow = v[9:0];
      2'h2: pick_narrow = v[19:10];
      2'h3: pick_narrow = v[29:20];
      default: pick_narrow = 10'h000;
    endcase
  endfunction

  function automatic logic pick_bit(logic [1:0] s, logic [2:0] v);
    unique case (s)
      2'h1: pick_bit = v[0];
      2'h2: pick_bit = v[1];
      2'h3: pick_bit = v[2];
      default: pick_bit = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // Bus slave
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [7:0] tmrs_ff;
  logic [1:0] outcfg_ff;
  logic [15:0] gen_reg_ff [2];
  logic [7:0] ctrl_ff [NU];
  logic [1:0] capsrc_ff [NU];
  logic [15:0] data_ff [NU];
  logic [31:0] nxt_rdata;
  logic acc;

  assign acc = hsel && htrans[1] && hready;

  // Zero-wait slave: every transfer completes in one data-phase cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      wr_pend_ff <= acc && hwrite;
      wr_addr_ff <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read data is taken at the address phase, so a read placed directly
  // behind a write to the same register sees the old value.
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    for (int i = 0; i < NU; i++) begin
      if (haddr[7:0] == 8'(i * cpc_pkg::UNIT_STRIDE) + cpc_pkg::OFS_CTRL) begin
        nxt_rdata[7:0] = ctrl_ff[i];
        nxt_rdata[cpc_pkg::CTRL_OUT_BIT] = unit_out[i];
      end
      if (haddr[7:0] == 8'(i * cpc_pkg::UNIT_STRIDE) + cpc_pkg::OFS_CAPSRC) begin
        nxt_rdata[1:0] = capsrc_ff[i];
      end
      if (haddr[7:0] == 8'(i * cpc_pkg::UNIT_STRIDE) + cpc_pkg::OFS_DLO) begin
        nxt_rdata[7:0] = data_ff[i][7:0];
      end
      if (haddr[7:0] == 8'(i * cpc_pkg::UNIT_STRIDE) + cpc_pkg::OFS_DHI) begin
        nxt_rdata[7:0] = data_ff[i][15:8];
      end
    end
    if (haddr[7:0] == cpc_pkg::OFS_TMRS) begin
      nxt_rdata[7:0] = tmrs_ff;
    end
    if (haddr[7:0] == cpc_pkg::OFS_OUTCFG) begin
      nxt_rdata[1:0] = outcfg_ff;
    end
    if (haddr[7:0] == cpc_pkg::OFS_GEN_A) begin
      nxt_rdata[15:0] = gen_reg_ff[0];
    end
    if (haddr[7:0] == cpc_pkg::OFS_GEN_B) begin
      nxt_rdata[15:0] = gen_reg_ff[1];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      hrdata <= nxt_rdata;
    end
  end

  // ==========================================================
  // Shared registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmrs_ff <= cpc_pkg::TMRS_RST;
      outcfg_ff <= cpc_pkg::OUTCFG_RST;
      gen_reg_ff[0] <= 16'h0000;
      gen_reg_ff[1] <= 16'h0000;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == cpc_pkg::OFS_TMRS) tmrs_ff <= hwdata[7:0];
      if (wr_addr_ff == cpc_pkg::OFS_OUTCFG) outcfg_ff <= hwdata[1:0];
      if (wr_addr_ff == cpc_pkg::OFS_GEN_A) gen_reg_ff[0] <= {hwdata[15], 5'h00, hwdata[9:0]};
      if (wr_addr_ff == cpc_pkg::OFS_GEN_B) gen_reg_ff[1] <= {hwdata[15], 5'h00, hwdata[9:0]};
    end
  end

  // ==========================================================
  // Input synchronisers
  logic [4:0] syn;

  cpc_sync #(.WIDTH(cpc_pkg::NUM_SRC)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({pin_change_signal, comparator_b_result, comparator_a_result, input_remap_pin}),
    .sync_out(syn)
  );

  // ==========================================================
  // PWM engines: two unit engines then two generators
  logic pwm_run [4];
  logic [PW-1:0] pwm_width [4];
  logic [PW-1:0] pwm_cnt [4];
  logic pwm_per [4];
  logic pwm_lvl [4];

  for (genvar p = 0; p < 4; p++) begin : g_pwm
    cpc_pwm #(.WIDTH(PW)) u_pwm (
      .hclk(hclk),
      .hresetn(hresetn),
      .run(pwm_run[p]),
      .width(pwm_width[p]),
      .cnt(pwm_cnt[p]),
      .period_start(pwm_per[p]),
      .level_ff(pwm_lvl[p])
    );
  end

  for (genvar g = 0; g < cpc_pkg::NUM_GENS; g++) begin : g_gen
    logic [1:0] gsel;
    assign gsel = tmrs_ff[5 + 2 * g -: 2];
    assign pwm_run[2 + g] = gen_reg_ff[g][cpc_pkg::GEN_EN_BIT] && (gsel != cpc_pkg::TSEL_NONE);
    assign pwm_width[2 + g] = gen_reg_ff[g][PW-1:0];
    assign pwm_cnt[2 + g] = pick_narrow(gsel, narrow_timer_cnt);
    assign pwm_per[2 + g] = pick_bit(gsel, narrow_timer_period);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) pwm_gen_out[g] <= 1'b0;
      else pwm_gen_out[g] <= pwm_lvl[2 + g];
    end
  end

  // ==========================================================
  // Units
  logic [1:0] tsel [NU];
  logic clr_req [NU];
  logic cap_evt [NU];
  logic match_evt [NU];
  logic [3:0] presc_ff [NU];

  for (genvar u = 0; u < NU; u++) begin : g_unit
    localparam logic [7:0] BASE = 8'(u * cpc_pkg::UNIT_STRIDE);
    logic en, active, is_pwm, is_cap, is_cmp, tok, src, src_prev_ff, rise, fall;
    logic match, match_prev_ff, nxt_out;
    logic [3:0] mode;
    logic [15:0] wide;

    assign tsel[u] = tmrs_ff[2 * u + 1 -: 2];
    assign tok = tsel[u] != cpc_pkg::TSEL_NONE;
    assign wide = pick_wide(tsel[u], wide_timer_val);
    assign en = ctrl_ff[u][cpc_pkg::CTRL_EN_BIT];
    assign mode = ctrl_ff[u][3:0];
    assign active = en && (mode != cpc_pkg::MODE_OFF);
    assign is_pwm = active && (mode[3:2] == cpc_pkg::MODE_PWM_TOP);
    assign is_cap = active && (mode >= cpc_pkg::MODE_CAP_ANY) && (mode <= cpc_pkg::MODE_CAP_16);
    assign is_cmp = active && !is_pwm && !is_cap;

    always_comb begin
      unique case (capsrc_ff[u])
        cpc_pkg::CTS_PIN: src = syn[u];
        cpc_pkg::CTS_CMP_A: src = syn[2];
        cpc_pkg::CTS_CMP_B: src = syn[3];
        default: src = syn[4];
      endcase
    end
    assign rise = src && !src_prev_ff;
    assign fall = !src && src_prev_ff;

    // The prescaler is cleared only outside capture, so a prescale change
    // while capturing can give an early capture.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        src_prev_ff <= 1'b0;
        presc_ff[u] <= 4'h0;
      end else begin
        src_prev_ff <= src;
        if (!is_cap) presc_ff[u] <= 4'h0;
        else if (rise) presc_ff[u] <= presc_ff[u] + 4'h1;
      end
    end

    always_comb begin
      cap_evt[u] = 1'b0;
      if (is_cap && tok) begin
        unique case (mode)
          cpc_pkg::MODE_CAP_ANY: cap_evt[u] = rise || fall;
          cpc_pkg::MODE_CAP_FALL: cap_evt[u] = fall;
          cpc_pkg::MODE_CAP_RISE: cap_evt[u] = rise;
          cpc_pkg::MODE_CAP_4: cap_evt[u] = rise && (presc_ff[u][1:0] == cpc_pkg::PRESC_4_LAST[1:0]);
          default: cap_evt[u] = rise && (presc_ff[u] == cpc_pkg::PRESC_16_LAST);
        endcase
      end
    end

    assign match = is_cmp && tok && (wide == data_ff[u]);
    assign match_evt[u] = match && !match_prev_ff;
    assign clr_req[u] = match_evt[u] &&
      ((mode == cpc_pkg::MODE_TOG_CLR) || (mode == cpc_pkg::MODE_PULSE_CLR));

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) match_prev_ff <= 1'b0;
      else match_prev_ff <= match;
    end

    // Control, source select and data pair; capture beats a bus write.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ctrl_ff[u] <= cpc_pkg::CTRL_RST;
        capsrc_ff[u] <= cpc_pkg::CAPSRC_RST;
        data_ff[u] <= cpc_pkg::DATA_RST;
      end else begin
        if (wr_pend_ff && wr_addr_ff == BASE + cpc_pkg::OFS_CTRL) ctrl_ff[u] <= hwdata[7:0] & 8'h9f;
        if (wr_pend_ff && wr_addr_ff == BASE + cpc_pkg::OFS_CAPSRC) capsrc_ff[u] <= hwdata[1:0];
        if (cap_evt[u]) data_ff[u] <= wide;
        else if (wr_pend_ff && wr_addr_ff == BASE + cpc_pkg::OFS_DLO) data_ff[u][7:0] <= hwdata[7:0];
        else if (wr_pend_ff && wr_addr_ff == BASE + cpc_pkg::OFS_DHI) data_ff[u][15:8] <= hwdata[7:0];
      end
    end

    // PWM width alignment
    assign pwm_run[u] = is_pwm && tok;
    assign pwm_cnt[u] = pick_narrow(tsel[u], narrow_timer_cnt);
    assign pwm_per[u] = pick_bit(tsel[u], narrow_timer_period);
    assign pwm_width[u] = ctrl_ff[u][cpc_pkg::CTRL_FMT_BIT] ?
      {data_ff[u][15:8], data_ff[u][7:6]} : {data_ff[u][9:8], data_ff[u][7:0]};

    // Output level
    always_comb begin
      nxt_out = unit_out[u];
      if (!active || is_cap) begin
        nxt_out = 1'b0;
      end else if (is_pwm) begin
        nxt_out = pwm_lvl[u];
      end else if (match_evt[u]) begin
        unique case (mode)
          cpc_pkg::MODE_TOG_CLR, cpc_pkg::MODE_TOG: nxt_out = !unit_out[u];
          cpc_pkg::MODE_SET: nxt_out = 1'b1;
          cpc_pkg::MODE_CLR: nxt_out = 1'b0;
          default: nxt_out = 1'b1;
        endcase
      end else if (mode == cpc_pkg::MODE_PULSE || mode == cpc_pkg::MODE_PULSE_CLR) begin
        nxt_out = 1'b0;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        unit_out[u] <= 1'b0;
        unit_out_oe[u] <= 1'b0;
        unit_flag_set[u] <= 1'b0;
      end else begin
        unit_out[u] <= nxt_out;
        unit_out_oe[u] <= (is_pwm || is_cmp) && (!outcfg_ff[u] || !nxt_out);
        unit_flag_set[u] <= cap_evt[u] || match_evt[u] || (pwm_run[u] && pwm_per[u]);
      end
    end
  end

  // ==========================================================
  // Timer clear pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wide_timer_clear <= 3'h0;
    end else begin
      wide_timer_clear <= 3'h0;
      for (int i = 0; i < NU; i++) begin
        if (clr_req[i]) wide_timer_clear[tsel[i] - 2'h1] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_off_low;
    !ctrl_ff[0][cpc_pkg::CTRL_EN_BIT] |=> !unit_out[0] && !unit_out_oe[0];
  endproperty
  a_off_low: assert property (p_off_low) else $error("disabled unit drives");

  property p_set_hold;
    (ctrl_ff[0] == 8'h88) && $past(ctrl_ff[0] == 8'h88) && $past(unit_out[0]) |-> unit_out[0];
  endproperty
  a_set_hold: assert property (p_set_hold) else $error("set level lost");

  property p_cap4;
    cap_evt[0] && (ctrl_ff[0][3:0] == cpc_pkg::MODE_CAP_4) |-> presc_ff[0][1:0] == 2'h3;
  endproperty
  a_cap4: assert property (p_cap4) else $error("fourth edge prescale wrong");

  property p_clr;
    clr_req[0] |=> wide_timer_clear[tsel[0] - 2'h1] ##1 !wide_timer_clear[tsel[0] - 2'h1];
  endproperty
  a_clr: assert property (p_clr) else $error("timer clear missing");

  property p_pulse;
    match_evt[0] && (ctrl_ff[0][3:0] == cpc_pkg::MODE_PULSE) ##1
      (ctrl_ff[0][3:0] == cpc_pkg::MODE_PULSE) |-> unit_out[0] ##1 !unit_out[0];
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse shape wrong");

  property p_flag;
    cap_evt[0] || match_evt[0] |=> unit_flag_set[0];
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set");

  property p_tsel_rst;
    $rose(hresetn) |-> tmrs_ff == 8'h55;
  endproperty
  a_tsel_rst: assert property (p_tsel_rst) else $error("timer select reset wrong");

  property p_capture;
    cap_evt[0] |=> data_ff[0] == $past(pick_wide(tsel[0], wide_timer_val));
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_upper_zero;
    ##1 hrdata[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("unused bits read nonzero");

  property p_no_timer;
    tsel[0] == 2'h0 |-> !match_evt[0] && !cap_evt[0];
  endproperty
  a_no_timer: assert property (p_no_timer) else $error("event without timer");

  c_capture: cover property (cap_evt[0]);
  c_match: cover property (match_evt[0] ##1 wide_timer_clear != 3'h0);
  c_pwm: cover property (pwm_run[0] && pwm_per[0] ##1 unit_flag_set[0]);
endmodule // cpc_top
`default_nettype wire

// ===== tb/cpc_timer_model.sv
// Behavioural timers that feed the capture/compare/PWM block.
`default_nettype none
module cpc_timer_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bench control
  input wire logic run,
  // Timer interface
  input wire logic [2:0] wide_timer_clear,
  output logic [47:0] wide_timer_val,
  output logic [29:0] narrow_timer_cnt,
  output logic [2:0] narrow_timer_period
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] cnt_ff;
  // ==========================================
  // Counters
  // The wide timers stall when run is low, so a capture lands on a known value.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wide_timer_val <= '0;
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 10'h001;
      for (int k = 0; k < 3; k++) begin
        if (wide_timer_clear[k]) begin
          wide_timer_val[16*k +: 16] <= 16'h0000;
        end else if (run) begin
          wide_timer_val[16*k +: 16] <= wide_timer_val[16*k +: 16] + 16'h0001;
        end
      end
    end
  end
  assign narrow_timer_cnt = {3{cnt_ff}};
  assign narrow_timer_period = {3{cnt_ff == 10'h000}};
endmodule // cpc_timer_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the capture/compare/PWM control block.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, run, hready, hreadyout, hresp;
  logic [1:0] htrans, unit_out, unit_out_oe, pwm_gen_out, unit_flag_set;
  logic [2:0] hsize, narrow_timer_period, wide_timer_clear;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [47:0] wide_timer_val;
  logic [29:0] narrow_timer_cnt;
  logic [3:0] src;
  logic [15:0] d;
  logic [3:0] modes [6] = '{4'h1, 4'h2, 4'h8, 4'h9, 4'ha, 4'hb};
  int err_count, comparisons, flags, exp, hi, hb, hu, tsel;
  assign hready = hreadyout;
  cpc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wide_timer_val(wide_timer_val),
    .wide_timer_clear(wide_timer_clear), .narrow_timer_cnt(narrow_timer_cnt),
    .narrow_timer_period(narrow_timer_period), .input_remap_pin({src[0], src[0]}),
    .comparator_a_result(src[1]), .comparator_b_result(src[2]), .pin_change_signal(src[3]),
    .unit_out(unit_out), .unit_out_oe(unit_out_oe), .pwm_gen_out(pwm_gen_out),
    .unit_flag_set(unit_flag_set));
  cpc_timer_model timers (.hclk(hclk), .hresetn(hresetn), .run(run),
    .wide_timer_clear(wide_timer_clear), .wide_timer_val(wide_timer_val),
    .narrow_timer_cnt(narrow_timer_cnt), .narrow_timer_period(narrow_timer_period));
  // ==========================================
  // Tasks
  // Starting on a fresh edge leaves one idle cycle, so a read never meets a fresh write.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      $display("MISMATCH %0t got %h want %h", $time, got, want);
      err_count++;
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    if (unit_flag_set[0] === 1'b1) begin
      flags <= flags + 1;
    end
  end
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    #500000;
    err_count++;
    report_and_stop();
  end
  // ==========================================
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, src} = '0;
    hsize = 3'h2;
    run = 1'b1;
    err_count = 0;
    comparisons = 0;
    flags = 0;
    void'($urandom(82744));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, cpc_pkg::OFS_TMRS, 0);
    chk(rd, 32'h55);
    ahb(1, 8'h30, 32'hff);
    ahb(0, 8'h30, 0);
    chk(rd, 0);
    ahb(1, cpc_pkg::OFS_CAPSRC, 32'hff);
    ahb(0, cpc_pkg::OFS_CAPSRC, 0);
    chk(rd, 32'h3);
    ahb(1, cpc_pkg::OFS_CTRL, 32'h7f);
    ahb(0, cpc_pkg::OFS_CTRL, 0);
    chk(rd, 32'h1f);
    for (int m = 3; m < 8; m++) begin
      ahb(1, cpc_pkg::OFS_CTRL, 0);
      ahb(1, cpc_pkg::OFS_CAPSRC, m % 4);
      ahb(1, cpc_pkg::OFS_CTRL, 32'h80 | m);
      repeat (1 + $urandom % 40) @(posedge hclk);
      run <= 1'b0;
      flags = 0;
      repeat (32) begin
        @(posedge hclk);
        src[m%4] <= ~src[m%4];
        repeat (3 + $urandom % 5) @(posedge hclk);
      end
      repeat (8) @(posedge hclk);
      exp = (m == 3) ? 32 : (m == 6) ? 4 : (m == 7) ? 1 : 16;
      chk(flags, exp);
      ahb(0, cpc_pkg::OFS_DLO, 0);
      chk(rd, wide_timer_val[7:0]);
      ahb(0, cpc_pkg::OFS_DHI, 0);
      chk(rd, wide_timer_val[15:8]);
      run <= 1'b1;
    end
    for (int k = 0; k < 6; k++) begin
      tsel = k % 3 + 1;
      ahb(1, cpc_pkg::OFS_CTRL, 0);
      ahb(1, cpc_pkg::OFS_TMRS, 32'h54 | tsel);
      ahb(1, cpc_pkg::OFS_OUTCFG, k % 2);
      d = wide_timer_val[16*(tsel-1) +: 16] + 16'h0064 + 16'($urandom % 200);
      ahb(1, cpc_pkg::OFS_DLO, d[7:0]);
      ahb(1, cpc_pkg::OFS_DHI, d[15:8]);
      ahb(1, cpc_pkg::OFS_CTRL, 32'h80 | modes[k]);
      hi = 0;
      do begin
        @(negedge hclk);
        hi++;
      end while (unit_flag_set[0] !== 1'b1 && hi < 600);
      exp = (modes[k] == 4'h9) ? 0 : 1;
      chk(unit_flag_set[0], 1);
      chk(unit_out[0], exp);
      chk(wide_timer_clear, (modes[k] == 1 || modes[k] == 4'hb) ? 1 << (tsel - 1) : 0);
      chk(unit_out_oe[0], (k % 2 == 1) ? 1 - exp : 1);
      exp = (modes[k] >= 4'ha) ? 0 : exp;
      ahb(0, cpc_pkg::OFS_CTRL, 0);
      chk(rd, 32'h80 | modes[k] | exp << 5);
    end
    for (int j = 0; j < 2; j++) begin
      ahb(1, cpc_pkg::OFS_TMRS, (j == 0) ? 32'h55 : 32'h54);
      ahb(1, cpc_pkg::OFS_CTRL, (j == 0) ? 32'h02 : 32'h82);
      d = wide_timer_val[15:0] + 16'h0032;
      ahb(1, cpc_pkg::OFS_DLO, d[7:0]);
      ahb(1, cpc_pkg::OFS_DHI, d[15:8]);
      flags = 0;
      repeat (700) @(posedge hclk);
      chk(flags, 0);
    end
    ahb(1, cpc_pkg::OFS_TMRS, 32'h55);
    ahb(1, cpc_pkg::OFS_DLO + 8'h10, 32'h2c);
    ahb(1, cpc_pkg::OFS_DHI + 8'h10, 32'h00);
    ahb(1, cpc_pkg::OFS_CTRL + 8'h10, 32'hcc);
    ahb(1, cpc_pkg::OFS_GEN_B, 32'h8064);
    for (int j = 0; j < 3; j++) begin
      ahb(1, cpc_pkg::OFS_DLO, (j == 1) ? 32'h40 : 32'h80);
      ahb(1, cpc_pkg::OFS_DHI, (j == 1) ? 32'h60 : 32'h01);
      ahb(1, cpc_pkg::OFS_CTRL, (j == 1) ? 32'hdc : 32'hcc);
      ahb(1, cpc_pkg::OFS_GEN_A, 32'h80c8);
      repeat (2) @(posedge narrow_timer_period[0]);
      hi = 0;
      hb = 0;
      hu = 0;
      repeat (1024) begin
        @(negedge hclk);
        hi += (j == 2) ? pwm_gen_out[0] : unit_out[0];
        hb += pwm_gen_out[1];
        hu += unit_out[1];
      end
      chk(hi, (j == 0) ? 384 : (j == 1) ? 385 : 200);
      chk(hb, 100);
      chk(hu, 44);
    end
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
